// ---- pkg/preset_ctrl_pkg.sv ----
// Package: register map, field layouts and timing for the preset/reset block
package preset_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PRESET = 12'h004;
  localparam logic [11:0] OFF_DWELL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFF_CMD = 12'h018;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // CTRL: [1:0] mode, [2] master, [4:3] reset select, [5] timer on B
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MASTER = 2;
  localparam int CTRL_RSEL_LSB = 3;
  localparam int CTRL_TIMER_B = 5;
  // PRESET: [2:0] mult A, [7:4] digit A, [10:8] mult B, [15:12] digit B
  localparam int PRE_MULT_A = 0;
  localparam int PRE_DIGIT_A = 4;
  localparam int PRE_MULT_B = 8;
  localparam int PRE_DIGIT_B = 12;
  // CMD: [0] manual reset push, [1] stop push, [2] count push
  localparam int CMD_RESET = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_COUNT = 2;
  // Interrupt bits: [0] preset, [1] dwell done, [2] general reset
  localparam int IRQ_PRESET = 0;
  localparam int IRQ_DWELL = 1;
  localparam int IRQ_GRESET = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [31:0] PRESET_RESET = 32'h0000_1010;

  // ----------------------------------------------------------------
  // Timing at 25 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int GRESET_US = 10;
  localparam int GRESET_CYC = (GRESET_US * CLK_HZ) / 1_000_000;
  localparam int DWELL_MIN_MS = 300;
  localparam int DWELL_MAX_MS = 10_000;
  localparam int POWERUP_MS = 500;
  localparam logic [31:0] DWELL_MIN_CYC =
    32'((64'(DWELL_MIN_MS) * CLK_HZ + 999) / 1000);
  localparam logic [31:0] DWELL_MAX_CYC =
    32'((64'(DWELL_MAX_MS) * CLK_HZ) / 1000);
  localparam logic [31:0] POWERUP_CYC =
    32'((64'(POWERUP_MS) * CLK_HZ) / 1000);
  localparam logic [31:0] DWELL_RESET = DWELL_MAX_CYC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_TEST = 2'b01,
    MODE_RECYCLE = 2'b10,
    MODE_ONE_CYCLE = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    DW_POWERUP = 2'b00,
    DW_IDLE = 2'b01,
    DW_RUN = 2'b10
  } dwell_state_t;

  typedef struct packed {
    logic [6:0] taps_a;
    logic [6:0] taps_b;
  } decade_taps_t;

  typedef struct packed {
    logic clear_a;
    logic clear_b;
    logic clear_timebase;
    logic running;
  } chan_ctrl_t;

endpackage : preset_ctrl_pkg

// ---- rtl/preset_reset_ctrl.sv ----
// Dual preset detection and reset control with APB register access
`timescale 1ns/1ps
// How it works
// - Multiplier picks raw input or decade carry
// - Digit m: m-th pulse sets preset flag
// - One decade counter, advances on trailing edge
// - Either channel's preset sets shared flag
// - Preset flag pulls system preset low
// - Flag rise starts dwell if allowed, test/recycle
// - Dwell emits one reset after 0.3-10 s
// - After reset, channels start new accumulation
// - Printer-off low blocks dwell triggering entirely
// - System preset line never triggers dwell
// - Power-up reset issued within 0.5 s
// - Local reset is dwell, external, or manual
// - Manual reset armed only by preset/stop
// - Master pulls system reset; slave never
// - Local or system reset gives 10us pulse
// - Pulse clears presets, flag, dividers, selected channels
// - Timer on B: pulse clears start/stop
// - Pulse stops counting, gating both channels
module preset_reset_ctrl
  import preset_ctrl_pkg::*;
#(
  parameter logic [31:0] POWERUP_CYCLES = POWERUP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decade taps of both channels, from counters on this clock
  input wire decade_taps_t taps,
  // Pins from outside
  input wire logic ext_reset,
  input wire logic printer_off_n,
  input wire logic sys_reset_n_in,
  // Open-drain system lines: enable high pulls low
  output logic sys_preset_oe,
  output logic sys_reset_oe,
  // Channel control
  output chan_ctrl_t chan,
  output logic general_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] preset;
    logic [31:0] dwell;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] ext_sync;
    logic [1:0] poff_sync;
    logic [1:0] srst_sync;
    logic [6:0] tap_prev_a;
    logic [6:0] tap_prev_b;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    logic flag;
    logic flag_prev;
    dwell_state_t dw_state;
    logic [31:0] dw_cnt;
    logic dw_pulse;
    logic manual_req;
    logic stop_latch;
    logic running;
    logic [15:0] gr_cnt;
    logic greset;
    logic local_prev;
    logic sys_preset_oe;
    logic sys_reset_oe;
    chan_ctrl_t chan;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [2:0] mult_a;
  logic [2:0] mult_b;
  logic [3:0] digit_a;
  logic [3:0] digit_b;
  logic trail_a;
  logic trail_b;
  logic hit_a;
  logic hit_b;
  logic preset_evt;
  logic dwell_ok;
  logic local_req;
  logic any_req;
  logic wr;
  logic rd;
  logic [IRQ_W-1:0] evt;
  mode_t mode;

  assign mode = mode_t'(s.ctrl[CTRL_MODE_LSB +: 2]);
  assign mult_a = s.preset[PRE_MULT_A +: 3];
  assign mult_b = s.preset[PRE_MULT_B +: 3];
  assign digit_a = s.preset[PRE_DIGIT_A +: 4];
  assign digit_b = s.preset[PRE_DIGIT_B +: 4];

  // Trailing edge of the selected tap; index 0 is raw input
  assign trail_a = (mult_a < 3'd7) && s.tap_prev_a[mult_a] &&
                   !taps.taps_a[mult_a];
  assign trail_b = (mult_b < 3'd7) && s.tap_prev_b[mult_b] &&
                   !taps.taps_b[mult_b];

  // Digit 0 treated as ten pulses; m-th pulse hits after m-1 counted
  assign hit_a = trail_a &&
    (s.cnt_a == ((digit_a == 4'd0) ? 4'd9 : digit_a - 4'd1));
  assign hit_b = trail_b &&
    (s.cnt_b == ((digit_b == 4'd0) ? 4'd9 : digit_b - 4'd1));
  assign preset_evt = hit_a || hit_b;

  // Only the local flag, never the system preset line, may trigger
  assign dwell_ok = s.poff_sync[1] &&
    (mode == MODE_TEST || mode == MODE_RECYCLE);

  assign local_req = s.dw_pulse || s.ext_sync[1] || s.manual_req;
  assign any_req = local_req || !s.srst_sync[1];

  assign wr = psel && penable && pwrite && !s.pready;
  assign rd = psel && penable && !pwrite && !s.pready;

  assign evt[IRQ_PRESET] = preset_evt && !s.flag;
  assign evt[IRQ_DWELL] = s.dw_pulse;
  assign evt[IRQ_GRESET] = any_req && !s.local_prev && !s.greset;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ext_sync = {s.ext_sync[0], ext_reset};
    next_s.poff_sync = {s.poff_sync[0], printer_off_n};
    next_s.srst_sync = {s.srst_sync[0], sys_reset_n_in};
    next_s.tap_prev_a = taps.taps_a;
    next_s.tap_prev_b = taps.taps_b;
    next_s.dw_pulse = 1'b0;
    next_s.manual_req = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // Preset counters: single decade each
    if (trail_a) begin
      next_s.cnt_a = (s.cnt_a == 4'd9) ? 4'd0 : s.cnt_a + 4'd1;
    end
    if (trail_b) begin
      next_s.cnt_b = (s.cnt_b == 4'd9) ? 4'd0 : s.cnt_b + 4'd1;
    end
    if (preset_evt) begin
      next_s.flag = 1'b1;
    end
    next_s.flag_prev = s.flag;

    // Dwell and power-up delay counter
    unique case (s.dw_state)
      DW_POWERUP: begin
        if (s.dw_cnt >= POWERUP_CYCLES - 32'd1) begin
          next_s.dw_pulse = 1'b1;
          next_s.dw_cnt = 32'h0000_0000;
          next_s.dw_state = DW_IDLE;
        end else begin
          next_s.dw_cnt = s.dw_cnt + 32'd1;
        end
      end
      DW_IDLE: begin
        if (s.flag && !s.flag_prev && dwell_ok) begin
          next_s.dw_cnt = 32'h0000_0000;
          next_s.dw_state = DW_RUN;
        end
      end
      DW_RUN: begin
        if (!s.poff_sync[1]) begin
          next_s.dw_state = DW_IDLE;
        end else if (s.dw_cnt >= s.dwell - 32'd1) begin
          next_s.dw_pulse = 1'b1;
          next_s.dw_state = DW_IDLE;
        end else begin
          next_s.dw_cnt = s.dw_cnt + 32'd1;
        end
      end
      default: next_s.dw_state = DW_IDLE;
    endcase

    // Start/stop latch
    if (wr && paddr == OFF_CMD && pwdata[CMD_STOP]) begin
      next_s.stop_latch = 1'b1;
    end
    if (wr && paddr == OFF_CMD && pwdata[CMD_COUNT]) begin
      next_s.stop_latch = 1'b0;
    end
    if (wr && paddr == OFF_CMD && pwdata[CMD_RESET] &&
        (s.flag || s.stop_latch)) begin
      next_s.manual_req = 1'b1;
    end
    next_s.running = !s.stop_latch && !s.greset;

    // General reset shaper; a request during the pulse is ignored, so a
    // master's own echo on the system line cannot stretch it
    next_s.local_prev = any_req;
    if (any_req && !s.local_prev && !s.greset) begin
      next_s.greset = 1'b1;
      next_s.gr_cnt = 16'(GRESET_CYC - 1);
    end else if (s.gr_cnt != 16'h0000) begin
      next_s.gr_cnt = s.gr_cnt - 16'd1;
    end else begin
      next_s.greset = 1'b0;
    end

    if (s.greset) begin
      next_s.cnt_a = 4'd0;
      next_s.cnt_b = 4'd0;
      next_s.flag = 1'b0;
      next_s.dw_state = (s.dw_state == DW_POWERUP) ? DW_POWERUP : DW_IDLE;
      next_s.running = 1'b0;
      if (s.ctrl[CTRL_TIMER_B]) begin
        next_s.stop_latch = 1'b0;
      end
    end

    // Channel gating; new accumulation after pulse ends
    next_s.chan.clear_a = s.greset && s.ctrl[CTRL_RSEL_LSB];
    next_s.chan.clear_b = s.greset && s.ctrl[CTRL_RSEL_LSB+1];
    next_s.chan.clear_timebase = s.greset;
    next_s.chan.running = s.running;

    next_s.sys_preset_oe = s.flag;
    next_s.sys_reset_oe = s.ctrl[CTRL_MASTER] && local_req;

    // Interrupts: set wins over clear
    next_s.irq_stat = s.irq_stat;
    if (wr && paddr == OFF_IRQ_STAT) begin
      next_s.irq_stat = s.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    next_s.irq_stat = next_s.irq_stat | evt;
    next_s.irq = |(s.irq_stat & s.irq_mask);

    // APB: one wait state, unmapped gives pslverr
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL: begin
          if (wr) next_s.ctrl = {26'h0, pwdata[5:0]};
          next_s.prdata = s.ctrl;
        end
        OFF_PRESET: begin
          if (wr) next_s.preset = pwdata & 32'h0000_F7F7;
          next_s.prdata = s.preset;
        end
        OFF_DWELL: begin
          if (wr) begin
            next_s.dwell = (pwdata < DWELL_MIN_CYC) ? DWELL_MIN_CYC :
                           (pwdata > DWELL_MAX_CYC) ? DWELL_MAX_CYC : pwdata;
          end
          next_s.prdata = s.dwell;
        end
        OFF_STATUS: begin
          next_s.prdata = {16'h0, s.cnt_b, s.cnt_a, 1'b0, s.dw_state,
                           s.greset, s.stop_latch, s.running,
                           !s.srst_sync[1], s.flag};
        end
        OFF_IRQ_STAT: next_s.prdata = {29'h0, s.irq_stat};
        OFF_IRQ_MASK: begin
          if (wr) next_s.irq_mask = pwdata[IRQ_W-1:0];
          next_s.prdata = {29'h0, s.irq_mask};
        end
        OFF_CMD: next_s.prdata = 32'h0000_0000;
        default: next_s.pslverr = 1'b1;
      endcase
      if (!rd) next_s.prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.preset <= PRESET_RESET;
      s.dwell <= DWELL_RESET;
      s.poff_sync <= 2'b11;
      s.srst_sync <= 2'b11;
      s.dw_state <= DW_POWERUP;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sys_preset_oe = s.sys_preset_oe;
  assign sys_reset_oe = s.sys_reset_oe;
  assign chan = s.chan;
  assign general_reset = s.greset;
  assign irq = s.irq;

endmodule : preset_reset_ctrl

// ---- sim/preset_reset_ctrl_asserts.sv ----
// Checker: timing properties at the preset/reset block's ports
`timescale 1ns/1ps
module preset_reset_ctrl_asserts
  import preset_ctrl_pkg::*;
#(
  parameter logic [31:0] POWERUP_CYCLES = POWERUP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset sources and outputs
  input wire logic ext_reset,
  input wire logic sys_reset_n_in,
  input wire logic sys_preset_oe,
  input wire chan_ctrl_t chan,
  input wire logic general_reset
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic seen;
  logic [31:0] width;
  logic [31:0] up;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
      width <= '0;
      up <= '0;
    end else begin
      seen <= seen | general_reset;
      width <= general_reset ? width + 32'h0000_0001 : '0;
      up <= up + 32'h0000_0001;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sync stages plus shaper register
  sequence gr_soon;
    ##[2:8] general_reset;
  endsequence
  AST_GR_WIDTH: assert property (
    $fell(general_reset) |-> width == 32'(GRESET_CYC))
    else $error("general reset width wrong");
  AST_EXT_RESET: assert property (
    $rose(ext_reset) |-> gr_soon)
    else $error("external reset gave no general reset");
  AST_SYS_LINE: assert property (
    $fell(sys_reset_n_in) |-> gr_soon)
    else $error("system reset line gave no general reset");
  AST_FLAG_CLEAR: assert property (
    $rose(general_reset) |-> ##[1:3] !sys_preset_oe)
    else $error("preset line not released by general reset");
  AST_CLEAR_SPAN: assert property (
    (chan.clear_a || chan.clear_b || chan.clear_timebase)
    |-> general_reset || $past(general_reset))
    else $error("channel clear outside general reset");
  AST_TB_CLEAR: assert property (
    general_reset && $past(general_reset) |-> chan.clear_timebase)
    else $error("time base not cleared");
  AST_GATE_OFF: assert property (
    $rose(general_reset) |-> ##[0:2] !chan.running)
    else $error("counting not gated off by general reset");
  AST_POWERUP: assert property (
    !seen |-> up < POWERUP_CYCLES + 32'h0000_0028)
    else $error("no power-up reset in time");
endmodule : preset_reset_ctrl_asserts

bind preset_reset_ctrl preset_reset_ctrl_asserts #(
  .POWERUP_CYCLES(POWERUP_CYCLES)
) chk (
  .pclk(pclk), .presetn(presetn), .ext_reset(ext_reset),
  .sys_reset_n_in(sys_reset_n_in), .sys_preset_oe(sys_preset_oe),
  .chan(chan), .general_reset(general_reset)
);

// ---- sim/far_side_model.sv ----
// Far side: counter decade taps, printout controller, system reset line
`timescale 1ns/1ps
module far_side_model
  import preset_ctrl_pkg::*;
(
  // Requests from the bench
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic [2:0] tap,
  input wire logic printer_on,
  input wire logic other,
  // Block side
  input wire logic sys_reset_oe,
  output decade_taps_t taps,
  output logic printer_off_n,
  output logic sys_reset_n
);
  // One tap at a time, so a wrong multiplier sees no edges
  assign taps.taps_a = pulse_a ? 7'(1 << tap) : 7'h00;
  assign taps.taps_b = pulse_b ? 7'(1 << tap) : 7'h00;
  assign printer_off_n = !printer_on;
  // Open-drain line with pull-up
  assign sys_reset_n = !(sys_reset_oe || other);
endmodule : far_side_model

// ---- sim/dual_preset_reset_control_bench.sv ----
// Testbench: preset detection, reset merging and registers over APB
`timescale 1ns/1ps
module dual_preset_reset_control_bench;
  import preset_ctrl_pkg::*;
  localparam int PU = 50;
  logic pclk = 1'b0, presetn = 1'b0, ext_reset = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, general_reset, sys_preset_oe;
  logic sys_reset_oe, printer_off_n, sys_reset_n;
  logic pulse_a = 1'b0, pulse_b = 1'b0, printer_on = 1'b0, other = 1'b0;
  logic [2:0] tap = 3'h0;
  decade_taps_t taps;
  chan_ctrl_t chan;
  int num_errors = 0, compares = 0, cycles = 0;
  preset_reset_ctrl #(.POWERUP_CYCLES(PU)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .taps(taps),
    .ext_reset(ext_reset), .printer_off_n(printer_off_n),
    .sys_reset_n_in(sys_reset_n), .sys_preset_oe(sys_preset_oe),
    .sys_reset_oe(sys_reset_oe), .chan(chan),
    .general_reset(general_reset), .irq(irq));
  far_side_model far (
    .pulse_a(pulse_a), .pulse_b(pulse_b), .tap(tap),
    .printer_on(printer_on), .other(other), .sys_reset_oe(sys_reset_oe),
    .taps(taps), .printer_off_n(printer_off_n), .sys_reset_n(sys_reset_n));
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Whole run needs a few thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready where it is settled, release after the edge it is seen
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(logic b, logic [2:0] s, int k);
    repeat (k) begin
      @(posedge pclk);
      tap <= s;
      pulse_a <= !b;
      pulse_b <= b;
      @(posedge pclk);
      pulse_a <= 1'b0;
      pulse_b <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask : pulse
  task automatic gr_wait(int lim, logic e);
    int n;
    n = 0;
    while (general_reset !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check("general_reset", e, general_reset);
  endtask : gr_wait
  task automatic gr_end;
    int n;
    n = 0;
    while (general_reset !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (6) @(posedge pclk);
  endtask : gr_end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    gr_wait(PU + 60, 1'b1);
    gr_end();
    apb(1'b0, OFF_CTRL, '0);
    check("ctrl", CTRL_RESET, rd);
    apb(1'b0, OFF_PRESET, '0);
    check("preset", PRESET_RESET, rd);
    apb(1'b1, OFF_DWELL, 32'h0000_0001);
    apb(1'b0, OFF_DWELL, '0);
    check("dwell", DWELL_MIN_CYC, rd);
    apb(1'b0, OFF_IRQ_STAT, '0);
    check("irq greset", 1'b1, rd[IRQ_GRESET]);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0007);
    apb(1'b0, OFF_IRQ_STAT, '0);
    check("irq stat", 32'h0000_0000, rd);
    apb(1'b0, 12'h01C, '0);
    check("unmapped", 1'b1, err);
    $display("test regs done");
  endtask : t_regs
  task automatic t_preset;
    apb(1'b1, OFF_PRESET, 32'h0000_0733);
    pulse(1'b0, 3'h2, 3);
    check("other tap", 1'b0, sys_preset_oe);
    pulse(1'b0, 3'h3, 2);
    check("early", 1'b0, sys_preset_oe);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
    pulse(1'b0, 3'h3, 1);
    check("preset line", 1'b1, sys_preset_oe);
    check("irq on", 1'b1, irq);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check("irq off", 1'b0, irq);
    apb(1'b1, OFF_CTRL, 32'h0000_001C);
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    gr_wait(20, 1'b1);
    repeat (3) @(posedge pclk);
    check("clear a", 1'b1, chan.clear_a);
    check("clear b", 1'b1, chan.clear_b);
    check("running", 1'b0, chan.running);
    check("flag gone", 1'b0, sys_preset_oe);
    gr_end();
    check("restart", 1'b1, chan.running);
    $display("test preset done");
  endtask : t_preset
  task automatic t_arm;
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    gr_wait(20, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h0000_0024);
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    gr_wait(20, 1'b1);
    gr_end();
    check("timer restart", 1'b1, chan.running);
    $display("test arm done");
  endtask : t_arm
  task automatic t_ext;
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    @(posedge pclk) ext_reset <= 1'b1;
    gr_wait(20, 1'b1);
    repeat (3) @(posedge pclk);
    check("slave line", 1'b0, sys_reset_oe);
    check("a kept", 1'b0, chan.clear_a);
    ext_reset <= 1'b0;
    gr_end();
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    @(posedge pclk) ext_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    check("master line", 1'b1, sys_reset_oe);
    ext_reset <= 1'b0;
    gr_end();
    @(posedge pclk) other <= 1'b1;
    repeat (3) @(posedge pclk);
    other <= 1'b0;
    gr_wait(20, 1'b1);
    gr_end();
    $display("test ext done");
  endtask : t_ext
  task automatic t_dwell;
    logic [1:0] m [4];
    m = '{MODE_NORMAL, MODE_ONE_CYCLE, MODE_RECYCLE, MODE_TEST};
    apb(1'b1, OFF_PRESET, 32'h0000_2307);
    for (int i = 0; i < 4; i++) begin
      printer_on <= (i == 2);
      apb(1'b1, OFF_CTRL, {29'h0, 1'b1, m[i]});
      pulse(1'b1, 3'h3, 2);
      check("b preset", 1'b1, sys_preset_oe);
      apb(1'b0, OFF_STATUS, '0);
      check("dwell", (i == 3) ? DW_RUN : DW_IDLE, rd[6:5]);
      if (i < 3) begin
        apb(1'b1, OFF_CMD, 32'h0000_0001);
        gr_wait(20, 1'b1);
        gr_end();
      end
    end
    $display("test dwell done");
  endtask : t_dwell
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_preset();
    t_arm();
    t_ext();
    t_dwell();
    test_done();
  end
endmodule : dual_preset_reset_control_bench
